// file: shared/srw_pkg.sv
// ==========================================================
// register map and field layout of the readout control block
package srw_pkg;
  // register byte addresses on the serial control port
  localparam logic [15:0] REG_HS_HI    = 16'h3020;
  localparam logic [15:0] REG_HS_LO    = 16'h3021;
  localparam logic [15:0] REG_VS_HI    = 16'h3022;
  localparam logic [15:0] REG_VS_LO    = 16'h3023;
  localparam logic [15:0] REG_HW_HI    = 16'h3024;
  localparam logic [15:0] REG_HW_LO    = 16'h3025;
  localparam logic [15:0] REG_VH_HI    = 16'h3026;
  localparam logic [15:0] REG_VH_LO    = 16'h3027;
  localparam logic [15:0] REG_SRC_SEL  = 16'h306c;
  localparam logic [15:0] REG_STROBE   = 16'h307a;
  localparam logic [15:0] REG_PATTERN  = 16'h307b;
  localparam logic [15:0] REG_ORIENT   = 16'h307c;
  localparam logic [15:0] REG_BAR_CTRL = 16'h307d;
  localparam logic [15:0] REG_TP_CTRL  = 16'h3080;
  localparam logic [15:0] REG_ARR_ORNT = 16'h3090;
  localparam logic [15:0] REG_CANCEL   = 16'h3301;
  localparam logic [15:0] REG_DELAY    = 16'h397c;
  localparam logic [15:0] REG_FRAMING  = 16'h30f0;
  localparam logic [15:0] REG_CW_HI    = 16'h30f1;
  localparam logic [15:0] REG_CW_LO    = 16'h30f2;
  localparam logic [15:0] REG_STATUS   = 16'h30f3;
  // field positions
  localparam int FLIP_BIT    = 0;
  localparam int MIRROR_BIT  = 1;
  localparam int ARR_MIR_BIT = 3;
  localparam int TP_ON_BIT   = 7;
  localparam int BAR_EN_BIT  = 7;
  localparam int SRC_NRM_BIT = 4;
  localparam int STB_EN_BIT  = 7;
  localparam int STB_POL_BIT = 6;
  localparam int STB_W_LSB   = 2;
  localparam int WC_BIT      = 2;
  localparam int BC_BIT      = 1;
  localparam int DELAY_BIT   = 1;
  localparam int PAD_BIT     = 2;
  localparam logic [1:0] PAT_COLOR_BAR = 2'b10;
  // reset values
  localparam logic [15:0] RST_CROP_HW = 16'h0800;
  localparam logic [15:0] RST_CROP_VH = 16'h0600;
  localparam logic [15:0] RST_COMP_W  = 16'h0100;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  typedef enum logic [1:0] {
    STB_XENON = 2'b00, STB_LED1 = 2'b01, STB_LED2 = 2'b10, STB_LED3 = 2'b11
  } srw_strobe_t;
  typedef enum logic [1:0] {
    FRM_NORMAL = 2'b00, FRM_COMP1 = 2'b01, FRM_COMP2 = 2'b10, FRM_RSVD = 2'b11
  } srw_frame_t;
  typedef enum logic {ST_SCAN = 1'b0, ST_PAD = 1'b1} srw_state_t;
endpackage : srw_pkg

// file: hdl/srw_readout.sv
module srw_readout
  import srw_pkg::*;
#(
  parameter int W      = 2048,
  parameter int H      = 1536,
  parameter int HBLANK = 16,
  parameter int VBLANK = 8
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  output logic      [15:0] arrayRow,
  output logic      [15:0] arrayCol,
  input  wire logic [9:0]  arrayData,
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [9:0]  outData,
  output logic             outLineValid,
  output logic             outFrameStart,
  output logic             outLineEnd,
  output logic             outBlueRow,
  output logic             outClkGate,
  output logic             strobeOut
);
  localparam int WW = 15;

  // ========================================================
  // register file
  logic [15:0] cropHs, cropVs, cropHw, cropVh, compWidth;
  logic [7:0]  srcSel, strobeCtl, patSel, orient, barCtl, tpCtl;
  logic [7:0]  arrOrient, cancelCtl, delayCtl, framing;
  logic        strobeActive;
  srw_state_t  state;
  logic [7:0]  next_rdData;

  // writes land in the cycle after regWrEn; crop pairs split by byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cropHs <= 16'h0000; cropVs <= 16'h0000;
      cropHw <= RST_CROP_HW; cropVh <= RST_CROP_VH;
      compWidth <= RST_COMP_W;
      srcSel <= RST_BYTE; strobeCtl <= RST_BYTE; patSel <= RST_BYTE;
      orient <= RST_BYTE; barCtl <= RST_BYTE; tpCtl <= RST_BYTE;
      arrOrient <= RST_BYTE; cancelCtl <= RST_BYTE;
      delayCtl <= RST_BYTE; framing <= RST_BYTE;
    end
    else if (regWrEn)
    begin
      unique case (regAddr)
        REG_HS_HI:    cropHs[15:8] <= regWrData;
        REG_HS_LO:    cropHs[7:0] <= regWrData;
        REG_VS_HI:    cropVs[15:8] <= regWrData;
        REG_VS_LO:    cropVs[7:0] <= regWrData;
        REG_HW_HI:    cropHw[15:8] <= regWrData;
        REG_HW_LO:    cropHw[7:0] <= regWrData;
        REG_VH_HI:    cropVh[15:8] <= regWrData;
        REG_VH_LO:    cropVh[7:0] <= regWrData;
        REG_SRC_SEL:  srcSel <= regWrData;
        REG_STROBE:   strobeCtl <= regWrData;
        REG_PATTERN:  patSel <= regWrData;
        REG_ORIENT:   orient <= regWrData;
        REG_BAR_CTRL: barCtl <= regWrData;
        REG_TP_CTRL:  tpCtl <= regWrData;
        REG_ARR_ORNT: arrOrient <= regWrData;
        REG_CANCEL:   cancelCtl <= regWrData;
        REG_DELAY:    delayCtl <= regWrData;
        REG_FRAMING:  framing <= regWrData;
        REG_CW_HI:    compWidth[15:8] <= regWrData;
        REG_CW_LO:    compWidth[7:0] <= regWrData;
        default:      ;
      endcase
    end
  end

  // readback; unmapped addresses and the status word's spare bits read 0
  always_comb
  begin
    next_rdData = 8'h00;
    unique case (regAddr)
      REG_HS_HI:    next_rdData = cropHs[15:8];
      REG_HS_LO:    next_rdData = cropHs[7:0];
      REG_VS_HI:    next_rdData = cropVs[15:8];
      REG_VS_LO:    next_rdData = cropVs[7:0];
      REG_HW_HI:    next_rdData = cropHw[15:8];
      REG_HW_LO:    next_rdData = cropHw[7:0];
      REG_VH_HI:    next_rdData = cropVh[15:8];
      REG_VH_LO:    next_rdData = cropVh[7:0];
      REG_SRC_SEL:  next_rdData = srcSel;
      REG_STROBE:   next_rdData = strobeCtl;
      REG_PATTERN:  next_rdData = patSel;
      REG_ORIENT:   next_rdData = orient;
      REG_BAR_CTRL: next_rdData = barCtl;
      REG_TP_CTRL:  next_rdData = tpCtl;
      REG_ARR_ORNT: next_rdData = arrOrient;
      REG_CANCEL:   next_rdData = cancelCtl;
      REG_DELAY:    next_rdData = delayCtl;
      REG_FRAMING:  next_rdData = framing;
      REG_CW_HI:    next_rdData = compWidth[15:8];
      REG_CW_LO:    next_rdData = compWidth[7:0];
      REG_STATUS:   next_rdData = {6'h00, state == ST_PAD, strobeActive};
      default:      next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
        regRdData <= next_rdData;
    end
  end

  // ========================================================
  // control decode
  wire        flipOn    = orient[FLIP_BIT];
  wire        mirrorOn  = orient[MIRROR_BIT];
  wire        arrMirror = arrOrient[ARR_MIR_BIT];
  wire        effMirror = mirrorOn ^ arrMirror;
  wire        delayOn   = delayCtl[DELAY_BIT];
  wire        barOn     = tpCtl[TP_ON_BIT]
                        && patSel[1:0] == PAT_COLOR_BAR
                        && barCtl[BAR_EN_BIT]
                        && !srcSel[SRC_NRM_BIT];
  wire        wcOn      = cancelCtl[WC_BIT];
  wire        bcOn      = cancelCtl[BC_BIT];
  wire        padOn     = framing[PAD_BIT];
  srw_frame_t frmMode;
  assign frmMode = srw_frame_t'(framing[1:0]);

  // ========================================================
  // scan counters and array addressing
  logic [15:0] col, row, compCnt;
  logic [9:0]  hist1, hist2;
  logic        push, inReady;

  wire [15:0] lastCol  = 16'(W + HBLANK - 1) + {15'h0000, delayOn};
  wire        atLastC  = col == lastCol;
  wire        atLastR  = row == 16'(H + VBLANK - 1);
  wire [15:0] x        = col - {15'h0000, delayOn};
  wire        actCol   = (col >= {15'h0000, delayOn}) && (x < 16'(W));
  wire        actRow   = row < 16'(H);
  wire        active   = actCol && actRow;
  // window test in output coordinates keeps crop independent of orientation
  wire        inWin    = active && x >= cropHs && (x - cropHs) < cropHw
                         && row >= cropVs && (row - cropVs) < cropVh;
  wire        winLast  = inWin && (x - cropHs) == cropHw - 16'h0001
                         && (row - cropVs) == cropVh - 16'h0001;
  wire [15:0] physRow  = flipOn ? 16'(H - 1) - row : row;
  assign arrayCol = effMirror ? 16'(W - 1) - x : x;
  assign arrayRow = physRow;
  // bayer rows alternate; even physical rows carry blue samples
  wire        blueRow  = !physRow[0];

  // ========================================================
  // pixel path: defect cancel, colour bar, crop mask
  function automatic logic [9:0] bar_level(input logic [2:0] idx);
    bar_level = {idx ^ 3'b111, 7'h7f};
  endfunction : bar_level

  wire        isWhite = arrayData == 10'h3ff;
  wire        isBlack = arrayData == 10'h000;
  // same-colour neighbour is two columns back in a bayer row
  wire [9:0]  pixC    = (wcOn && isWhite) || (bcOn && isBlack) ? hist2 : arrayData;
  wire [9:0]  pixS    = barOn ? bar_level(x[WW -: 3]) : pixC;
  wire [9:0]  pixM    = inWin ? pixS : 10'h000;

  // ========================================================
  // framing of each word pushed into the buffer
  wire        compEol = compCnt == compWidth - 16'h0001;
  logic       wLv, wSof, wEol, wHas;
  logic [9:0] wData;

  always_comb
  begin
    wData = pixM;
    wSof  = col == 16'h0000 && row == 16'h0000;
    wLv   = active;
    wEol  = active && x == 16'(W - 1);
    wHas  = 1'b1;
    if (state == ST_PAD)
    begin
      // dummy words finish the short last line
      wData = 10'h000;
      wSof  = 1'b0;
      wLv   = 1'b1;
      wEol  = compEol;
      wHas  = 1'b1;
    end
    else if (frmMode == FRM_COMP1)
    begin
      wLv  = actRow;
      wEol = 1'b0;
      wHas = inWin;
    end
    else if (frmMode == FRM_COMP2)
    begin
      wLv  = inWin;
      wEol = inWin && (compEol || (winLast && !padOn));
      wHas = inWin;
    end
  end

  // the scan stalls whenever the buffer is full, so no word is lost
  assign push = inReady;
  wire padStart = frmMode == FRM_COMP2 && padOn && winLast && !compEol;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      col <= 16'h0000; row <= 16'h0000; compCnt <= 16'h0000;
      hist1 <= 10'h000; hist2 <= 10'h000; state <= ST_SCAN;
    end
    else if (push)
    begin
      unique case (state)
        ST_SCAN:
        begin
          col <= atLastC ? 16'h0000 : col + 16'h0001;
          if (atLastC)
            row <= atLastR ? 16'h0000 : row + 16'h0001;
          if (active)
          begin
            hist1 <= pixC;
            hist2 <= hist1;
          end
          if (inWin)
            compCnt <= wEol && !padStart ? 16'h0000 : compCnt + 16'h0001;
          if (padStart)
            state <= ST_PAD;
        end
        ST_PAD:
        begin
          compCnt <= compEol ? 16'h0000 : compCnt + 16'h0001;
          if (compEol)
            state <= ST_SCAN;
        end
      endcase
    end
  end

  // ========================================================
  // strobe generator
  logic [2:0] stbLines;
  srw_strobe_t stbMode;
  assign stbMode = srw_strobe_t'(strobeCtl[1:0]);
  wire stbReq  = regWrEn && regAddr == REG_STROBE && regWrData[STB_EN_BIT];
  wire lineEnd = push && state == ST_SCAN && atLastC;
  wire frmEnd  = lineEnd && atLastR;
  wire stbDone = !strobeCtl[STB_EN_BIT]
                 || (stbMode == STB_XENON && lineEnd && stbLines == 3'd0)
                 || ((stbMode == STB_LED1 || stbMode == STB_LED2) && frmEnd);

  // a new request wins over an ending pulse in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strobeActive <= 1'b0;
      stbLines     <= 3'd0;
      strobeOut    <= 1'b0;
    end
    else
    begin
      if (stbReq)
      begin
        strobeActive <= 1'b1;
        stbLines     <= {1'b0, regWrData[STB_W_LSB +: 2]};
      end
      else if (strobeActive && stbDone)
        strobeActive <= 1'b0;
      else if (lineEnd && stbLines != 3'd0)
        stbLines <= stbLines - 3'd1;
      strobeOut <= strobeActive ^ strobeCtl[STB_POL_BIT];
    end
  end

  // ========================================================
  // two-entry output buffer
  localparam int BW = 15;
  logic [BW-1:0] bufMem [2];
  logic          wrPtr, rdPtr, outHas;
  logic [1:0]    bufCnt;
  wire           pop = outValid && outReady;
  assign inReady  = bufCnt != 2'd2;
  assign outValid = bufCnt != 2'd0;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= 1'b0; rdPtr <= 1'b0; bufCnt <= 2'd0;
      bufMem[0] <= '0; bufMem[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        bufMem[wrPtr] <= {wData, wLv, wSof, wEol, blueRow && wHas, wHas};
        wrPtr <= ~wrPtr;
      end
      if (pop)
        rdPtr <= ~rdPtr;
      bufCnt <= bufCnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // the has-data flag rides in the lowest bit as the gate qualifier of each word
  assign {outData, outLineValid, outFrameStart, outLineEnd, outBlueRow, outHas} = bufMem[rdPtr];
  assign outClkGate = outValid && outHas;

  // ========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_mirror_first: assert property (
    active && effMirror && x == 16'h0000 |-> arrayCol == 16'(W - 1))
    else $error("mirror does not start at the last column");
  chk_delay_lead: assert property (
    delayOn && col == 16'h0000 && state == ST_SCAN
    |-> !actCol && wData == 10'h000 && (!wLv || frmMode == FRM_COMP1))
    else $error("delayed row shows a pixel in its lead slot");
  chk_blue_flip: assert property (
    flipOn && row == 16'h0000 |-> blueRow == (16'(H - 1) % 2 == 0))
    else $error("row colour wrong under flip");
  chk_flip_first: assert property (
    flipOn && row == 16'h0000 |-> arrayRow == 16'(H - 1))
    else $error("flip does not start at the last row");
  chk_crop_mask: assert property (
    push && state == ST_SCAN && !inWin |-> wData == 10'h000)
    else $error("pixel outside crop window not masked");
  chk_crop_timing: assert property (
    push && frmMode == FRM_NORMAL && state == ST_SCAN |-> wLv == active)
    else $error("crop changed line valid timing");
  chk_bar_select: assert property (
    push && inWin && barOn |-> wData == bar_level(x[WW -: 3]))
    else $error("colour bar not sent");
  chk_white_cancel: assert property (
    push && inWin && !barOn && wcOn && isWhite && hist2 != 10'h3ff
    |-> wData != 10'h3ff)
    else $error("white defect passed through");
  chk_strobe_start: assert property (
    stbReq |=> ##1 strobeOut != $past(regWrData[STB_POL_BIT], 2))
    else $error("strobe not at active level two cycles after request");
  chk_comp1_lv: assert property (
    push && state == ST_SCAN && frmMode == FRM_COMP1 && actRow |-> wLv)
    else $error("line valid dropped inside frame in first mode");
  chk_pad_end: assert property (
    state == ST_PAD && push && compEol |=> state == ST_SCAN)
    else $error("padding did not end at line width");
  chk_buf_full: assert property (
    bufCnt == 2'd2 && !outReady |=> bufCnt == 2'd2 && !inReady)
    else $error("buffer lost a word while stalled");

  cov_strobe: cover property (stbReq ##[1:20] strobeOut != strobeCtl[STB_POL_BIT]);
  cov_pad: cover property (padStart && push);
  cov_full: cover property (bufCnt == 2'd2);
  cov_sof: cover property (pop && outFrameStart);
endmodule : srw_readout

// file: verif/srw_host_model.sv
module srw_host_model
(
  input  wire logic        sys_clk,
  input  wire logic        stallEn,
  input  wire logic        defectOn,
  input  wire logic [15:0] arrayRow,
  input  wire logic [15:0] arrayCol,
  output logic      [9:0]  arrayData,
  output logic             outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // pixel array: ramp, plus one stuck-white and one stuck-black site on row 3
  always_comb
  begin
    arrayData = 10'(arrayRow * 20 + arrayCol + 1);
    if (defectOn && arrayRow == 3 && arrayCol == 5) arrayData = 10'h3ff;
    if (defectOn && arrayRow == 3 && arrayCol == 9) arrayData = 10'h000;
  end
  // ==========================================
  // receiver: stalls one slot in four so the buffer fills and drains
  initial
  begin
    outReady = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      outReady <= !stallEn || ($urandom % 4 != 0);
    end
  end
endmodule : srw_host_model

// file: verif/tb_sensor_readout_window_strobe.sv
module tb_sensor_readout_window_strobe
  import srw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 16;
  localparam int H = 8;
  localparam int HB = 2;
  // orientation, array mirror, delay and cancel settings of each stream case
  localparam logic [7:0] ORI [9] = '{8'h00, 8'h02, 8'h01, 8'h01, 8'h02, 8'h00, 8'h03, 8'h00,
                                     8'h00};
  localparam logic [7:0] ARR [9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
                                     8'h00};
  localparam logic [7:0] DLY [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
                                     8'h00};
  localparam logic [7:0] CAN [9] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00,
                                     8'h00};
  localparam logic [15:0] RA [8] = '{REG_SRC_SEL, REG_STROBE, REG_PATTERN, REG_ORIENT,
                                     REG_BAR_CTRL, REG_TP_CTRL, REG_ARR_ORNT, REG_CANCEL};
  logic        sys_clk, rst, regWrEn, regRdEn, regRdValid, outValid, outReady;
  logic        outLineValid, outFrameStart, outLineEnd, outBlueRow, strobeOut, outClkGate;
  logic        stallEn, defectOn, mir, flp, dly, bar, wc, bc, stbPol, cm;
  logic [15:0] regAddr, arrayRow, arrayCol, a;
  logic [7:0]  regWrData, regRdData, d;
  logic [9:0]  arrayData, outData;
  logic [7:0]  rdQ [$];
  int          hs, vs, hw, vh, col, row, framesDone, lec, cycles, mismatches, nTests;
  bit          armReq, skip, checking;

  srw_readout #(.W(W), .H(H), .HBLANK(HB), .VBLANK(2)) srw_readout_inst (
    .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .arrayRow(arrayRow), .arrayCol(arrayCol), .arrayData(arrayData), .outValid(outValid),
    .outReady(outReady), .outData(outData), .outLineValid(outLineValid),
    .outFrameStart(outFrameStart), .outLineEnd(outLineEnd), .outBlueRow(outBlueRow),
    .outClkGate(outClkGate), .strobeOut(strobeOut));
  srw_host_model srw_host_model_inst (
    .sys_clk(sys_clk), .stallEn(stallEn), .defectOn(defectOn), .arrayRow(arrayRow),
    .arrayCol(arrayCol), .arrayData(arrayData), .outReady(outReady));

  // ==========================================
  // helpers
  task automatic check(string nm, logic [9:0] seen, logic [9:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : testDone

  task automatic wr(logic [15:0] ad, logic [7:0] dt);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= ad;
    regWrData <= dt;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic wr16(logic [15:0] ad, logic [15:0] v);
    wr(ad, v[15:8]);
    wr(ad + 16'h0001, v[7:0]);
  endtask : wr16

  // the expected byte is noted now and compared when the answer shows
  task automatic rd(logic [15:0] ad, logic [7:0] exp);
    rdQ.push_back(exp);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= ad;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
  endtask : rd

  function automatic logic [9:0] raw(int r, int c);
    raw = 10'(r * 20 + c + 1);
    if (defectOn && r == 3 && c == 5) raw = 10'h3ff;
    if (defectOn && r == 3 && c == 9) raw = 10'h000;
  endfunction : raw

  // a cancelled defect takes the pixel two columns back
  function automatic logic [9:0] pix(int r, int c);
    logic [9:0] v;
    v = raw(r, c);
    if ((wc && v == 10'h3ff) || (bc && v == 10'h000)) v = raw(r, c - 2);
    pix = bar ? 10'h3ff : v;
  endfunction : pix

  // cm marks the first framing mode: one line valid per frame, gate only on window words
  task automatic checkSlot();
    int         x, px, py;
    logic       act, win;
    logic [9:0] e;
    x = col - dly;
    act = x >= 0 && x < W && row < H;
    win = act && x >= hs && x < hs + hw && row >= vs && row < vs + vh;
    check("outLineValid", 10'(outLineValid), 10'(cm ? row < H : act));
    check("outLineEnd", 10'(outLineEnd), 10'(!cm && act && x == W - 1));
    check("outClkGate", 10'(outClkGate), 10'(!cm || win));
    if (act)
    begin
      px = mir ? W - 1 - x : x;
      py = flp ? H - 1 - row : row;
      // outside the crop window the pixel is masked to zero
      e = win ? pix(py, px) : 10'h000;
      check("outData", outData, e);
      if (!bar) check("outBlueRow", 10'(outBlueRow), 10'(py % 2 == 0 && (!cm || win)));
    end
  endtask : checkSlot

  task automatic waitFrame();
    int n;
    n = framesDone;
    for (int i = 0; i < 3000 && framesDone == n; i++) @(posedge sys_clk);
    check("frameDone", 10'(framesDone != n), 10'd1);
  endtask : waitFrame

  // ==========================================
  // clock and hang guard
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      testDone();
    end
  end

  // ==========================================
  // read answers are taken off the queue as they appear
  always @(posedge sys_clk)
    if (!rst && regRdValid === 1'b1)
    begin
      if (rdQ.size() == 0) check("regRdValid", 10'd1, 10'd0);
      else check("regRdData", 10'(regRdData), 10'(rdQ.pop_front()));
    end

  // stream watcher: tracks the slot, and checks a whole frame once armed;
  // one frame is skipped first since the buffer may hold words from before
  always @(posedge sys_clk)
    if (!rst && outValid === 1'b1 && outReady)
    begin
      if (outFrameStart === 1'b1)
      begin
        col = 0;
        row = 0;
        if (checking)
        begin
          framesDone++;
          checking = 0;
          armReq = 0;
        end
        else if (armReq)
        begin
          checking = !skip;
          skip = 0;
        end
      end
      if (checking) checkSlot();
      col++;
      // a scan line period ends here, blank rows included, as the strobe counts them
      if (col == W + HB + dly)
      begin
        if (strobeOut !== stbPol) lec++;
        col = 0;
        row++;
      end
    end

  // ==========================================
  // main sequence
  initial
  begin
    {rst, stallEn} = 2'b11;
    {regWrEn, regRdEn, defectOn, mir, flp, dly, bar, wc, bc, stbPol, cm} = '0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    void'($urandom(95370));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, then random write and read back of the crop bytes
    for (int i = 0; i < 16; i++)
    begin
      a = (i < 8) ? 16'h3020 + 16'(i) : RA[i - 8];
      rd(a, (a == REG_HW_HI) ? 8'h08 : (a == REG_VH_HI) ? 8'h06 : 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      if (i == 3) d[0] = 1'b0;
      wr(16'h3020 + 16'(i), d);
      rd(16'h3020 + 16'(i), d);
    end
    rd(16'h3100, 8'h00);
    // readout cases: white cancel, mirror, flip, array mirror, delay, both cancels, crop, bar, framing one
    for (int k = 0; k < 9; k++)
    begin
      bar = (k == 7);
      wr(REG_ORIENT, ORI[k]);
      wr(REG_ARR_ORNT, ARR[k]);
      wr(REG_DELAY, DLY[k]);
      wr(REG_CANCEL, CAN[k]);
      wr(REG_TP_CTRL, bar ? 8'h80 : 8'h00);
      wr(REG_PATTERN, 8'h02);
      wr(REG_BAR_CTRL, bar ? 8'h80 : 8'h00);
      wr(REG_SRC_SEL, bar ? 8'h00 : 8'h10);
      wr(REG_FRAMING, (k == 8) ? 8'h01 : 8'h00);
      hs = (k == 6) ? 2 : 0;
      vs = hs;
      hw = (k == 6) ? 4 : 2048;
      vh = (k == 6) ? 2 : 1536;
      wr16(REG_HS_HI, 16'(hs));
      wr16(REG_VS_HI, 16'(vs));
      wr16(REG_HW_HI, 16'(hw));
      wr16(REG_VH_HI, 16'(vh));
      mir = ORI[k][1] ^ ARR[k][3];
      flp = ORI[k][0];
      dly = DLY[k][1];
      wc = CAN[k][2];
      bc = CAN[k][1];
      cm = (k == 8);
      defectOn = CAN[k] != 8'h00;
      skip = 1;
      armReq = 1;
      waitFrame();
    end
    // strobe: xenon at four lines, both pulse modes, continuous mode;
    // no stalls here, so each line's last word leaves one cycle after its scan
    stallEn <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      stbPol = m[0];
      wr(REG_STROBE, {1'b0, stbPol, 6'b00_0000});
      @(posedge sys_clk);
      #1;
      check("strobeIdle", 10'(strobeOut), 10'(stbPol));
      lec = 0;
      wr(REG_STROBE, {1'b1, stbPol, 2'b00, 2'(3 - m), 2'(m)});
      @(posedge sys_clk);
      #1;
      check("strobeOn", 10'(strobeOut), 10'(!stbPol));
      if (m == 3)
      begin
        repeat (400) @(posedge sys_clk);
        check("strobeHold", 10'(strobeOut), 10'(!stbPol));
        wr(REG_STROBE, {1'b0, stbPol, 6'b00_0011});
        // the cleared enable ends the pulse one cycle later, the pin one more
        repeat (2) @(posedge sys_clk);
        #1;
      end
      else
        for (int i = 0; i < 2000 && strobeOut !== stbPol; i++) @(posedge sys_clk);
      check("strobeOff", 10'(strobeOut), 10'(stbPol));
      if (m == 0) check("lineEnds", 10'(lec), 10'd4);
    end
    testDone();
  end
endmodule : tb_sensor_readout_window_strobe
